// file: bertb_core.sv
// BERT transmit error insertion, receive status flags and saturating tallies for one port
// ==========================================================================
// Summary of operation
// - Rate field 0 disables; n inverts one bit in every ten to the n.
// - Single error enable gates all single error insertion.
// - Register trigger rising edge inserts exactly one error when selected and enabled.
// - Several trigger rises between opportunities still insert only one error.
// - Source select picks register trigger (0) or external insert input (1).
// - Update done rises once a requested tally update has completed.
// - Update done falls when the selected update request falls.
// - Count nonzero shows tally above zero; cleared on a counter update.
// - Out of sync status mirrors the checker's lock state.
// - Update done latched sets on each rise of update done.
// - Bit error latched sets on any detected bit error.
// - Count nonzero latched sets on rise of count nonzero.
// - Out of sync latched sets on every change of out of sync.
// - Update done latched interrupts only when its enable is set.
// - Other latched flags interrupt only with own enable and port enable.
// - 24-bit error tally counts errors, saturating at all ones.
// - Error tally holds while out of sync.
// - 32-bit bit tally counts received bits, saturating at all ones.
// - Bit tally holds while out of sync.
// - Readable tallies change only on the counter update strobe.
// - Error tally read as low sixteen bits then upper eight.
// - Bit tally read as low sixteen bits then upper sixteen.
// - Rate insertion starts when a nonzero rate is written.
// - A new rate applies only after the next error at the old rate.
`timescale 1ns/100ps
`default_nettype none
`include "bertb_defs.svh"
module bertb_core
	import bertb_pkg::*;
#(
	parameter int ERR_W = 24,
	parameter int BIT_W = 32,
	parameter int PORTS = 4
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic tx_bit_valid,
	input wire logic tx_data_in,
	output logic tx_data_out,
	input wire logic external_error_insert_input,
	input wire logic rx_bit_valid,
	input wire logic rx_data,
	input wire logic rx_expected,
	input wire logic out_of_sync_in,
	input wire logic global_update_request,
	input wire logic port_irq_enable,
	output logic irq_request
);
	// ======================================================================
	// Elaboration checks
	generate
		if (ERR_W != 24 || BIT_W != 32 || PORTS < 1 || PORTS > 4)
		begin : g_bad
			$error("bertb_core: tally widths must be 24 and 32, ports 1 to 4");
		end
	endgenerate

	// Rate limits per rate code: ten to the n, minus one
	function automatic logic [23:0] rate_limit(input logic [2:0] n);
		case (n)
			3'h1: rate_limit = 24'h000009;
			3'h2: rate_limit = 24'h000063;
			3'h3: rate_limit = 24'h0003e7;
			3'h4: rate_limit = 24'h00270f;
			3'h5: rate_limit = 24'h01869f;
			3'h6: rate_limit = 24'h0f423f;
			3'h7: rate_limit = 24'h98967f;
			default: rate_limit = 24'h000000;
		endcase
	endfunction

	// Register index from a word address; top digit selects port
	function automatic logic [7:0] reg_index(input logic [9:0] a);
		reg_index = {2'b00, a[4:0], 1'b0} + 8'h60;
	endfunction

	// ======================================================================
	// Avalon-MM slave
	bertb_req_s req;
	logic [1:0] port_sel;
	logic [7:0] idx;
	logic sel_here;
	logic wr;
	logic rd_pend_reg;
	logic [15:0] ctrl_reg;
	logic [1:0] updctl_reg;
	logic [3:0] latched_reg;
	logic [3:0] irqen_reg;
	logic [3:0] status;
	logic [ERR_W-1:0] err_snap_reg;
	logic [BIT_W-1:0] bit_snap_reg;
	logic [15:0] rd_mux;

	assign req = '{read: avs_read, write: avs_write, address: avs_address,
		writedata: avs_writedata};
	// Word address: bits 9:8 pick port digit 0 to 3; bits 4:0 pick register
	assign port_sel = req.address[9:8];
	assign idx = reg_index(req.address);
	assign sel_here = (port_sel == 2'h0) && (req.address[7:5] == 3'h1);
	assign wr = clk_en && req.write && sel_here;
	// Reads answer one cycle late so read data comes from a flop
	assign avs_waitrequest = req.read && !rd_pend_reg;

	always_comb
	begin
		rd_mux = `BERTB_RST16;
		case (idx)
			`BERTB_IDX_CTRL: rd_mux = ctrl_reg;
			`BERTB_IDX_STATUS: rd_mux = {12'h000, status};
			`BERTB_IDX_LATCHED: rd_mux = {12'h000, latched_reg};
			`BERTB_IDX_IRQEN: rd_mux = {12'h000, irqen_reg};
			`BERTB_IDX_UPDCTL: rd_mux = {14'h0000, updctl_reg};
			`BERTB_IDX_ERR_LO: rd_mux = err_snap_reg[15:0];
			`BERTB_IDX_ERR_HI: rd_mux = {8'h00, err_snap_reg[23:16]};
			`BERTB_IDX_BIT_LO: rd_mux = bit_snap_reg[15:0];
			`BERTB_IDX_BIT_HI: rd_mux = bit_snap_reg[31:16];
			default: rd_mux = `BERTB_RST16;
		endcase
		if (!sel_here)
			rd_mux = `BERTB_RST16;
	end

	// Read data capture; unmapped addresses read zero
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_pend_reg <= 1'b0;
			avs_readdata <= 32'h00000000;
		end
		else if (clk_en)
		begin
			rd_pend_reg <= req.read && !rd_pend_reg;
			if (req.read && !rd_pend_reg)
				avs_readdata <= {16'h0000, rd_mux};
		end
	end

	// Control registers
	logic rate_written;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= `BERTB_RST16;
			irqen_reg <= `BERTB_RST4;
			updctl_reg <= 2'h0;
			rate_written <= 1'b0;
		end
		else if (clk_en)
		begin
			rate_written <= 1'b0;
			if (wr && idx == `BERTB_IDX_CTRL)
			begin
				ctrl_reg <= {10'h000, req.writedata[5:0]};
				rate_written <= 1'b1;
			end
			if (wr && idx == `BERTB_IDX_IRQEN)
				irqen_reg <= req.writedata[3:0];
			if (wr && idx == `BERTB_IDX_UPDCTL)
				updctl_reg <= req.writedata[1:0];
		end
	end

	// ======================================================================
	// Transmit error insertion
	logic [2:0] rate_new;
	logic [2:0] rate_act_reg;
	logic [23:0] rate_cnt_reg;
	logic rate_pend_reg;
	logic trig_src;
	logic trig_prev_reg;
	logic single_pend_reg;
	logic rate_hit;

	assign rate_new = ctrl_reg[`BERTB_CTL_RATE_MSB:`BERTB_CTL_RATE_LSB];
	// Source mux; toggling the select with a high source looks like an edge
	assign trig_src = ctrl_reg[`BERTB_CTL_SRC] ? external_error_insert_input
		: ctrl_reg[`BERTB_CTL_TRIG];
	assign rate_hit = tx_bit_valid && (rate_act_reg != 3'h0)
		&& (rate_cnt_reg == rate_limit(rate_act_reg));

	// Rate counter; a new rate waits for the next error when running
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rate_act_reg <= 3'h0;
			rate_cnt_reg <= 24'h000000;
			rate_pend_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (rate_written && (rate_act_reg == 3'h0))
			begin
				rate_act_reg <= rate_new;
				rate_cnt_reg <= 24'h000000;
			end
			else
			begin
				if (rate_written)
					rate_pend_reg <= 1'b1;
				if (rate_hit)
				begin
					rate_cnt_reg <= 24'h000000;
					if (rate_pend_reg || rate_written)
					begin
						rate_act_reg <= rate_new;
						rate_pend_reg <= 1'b0;
					end
				end
				else if (tx_bit_valid && rate_act_reg != 3'h0)
					rate_cnt_reg <= rate_cnt_reg + 24'h000001;
			end
		end
	end

	// Single error request; repeated edges collapse into one pending error
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trig_prev_reg <= 1'b0;
			single_pend_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			trig_prev_reg <= trig_src;
			if (trig_src && !trig_prev_reg && ctrl_reg[`BERTB_CTL_SINGLE_EN])
				single_pend_reg <= 1'b1;
			else if (tx_bit_valid || !ctrl_reg[`BERTB_CTL_SINGLE_EN])
				single_pend_reg <= 1'b0;
		end
	end

	// Transmit bit with inversion applied
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_data_out <= 1'b0;
		else if (clk_en && tx_bit_valid)
			tx_data_out <= tx_data_in ^ (rate_hit || (single_pend_reg
				&& ctrl_reg[`BERTB_CTL_SINGLE_EN]));
	end

	// ======================================================================
	// Receive tallies and counter update
	logic [ERR_W-1:0] err_cnt_reg;
	logic [BIT_W-1:0] bit_cnt_reg;
	logic bit_err;
	logic upd_req;
	logic upd_prev_reg;
	logic upd_done_reg;
	logic cnz_reg;
	logic oos_prev_reg;
	logic cnz_prev_reg;
	logic upd_done_prev_reg;
	bertb_upd_e upd_state;

	assign bit_err = rx_bit_valid && !out_of_sync_in && (rx_data != rx_expected);
	assign upd_req = updctl_reg[`BERTB_UPD_SRC] ? global_update_request
		: updctl_reg[`BERTB_UPD_LOCAL];

	// Live counters; the snapshot reloads them with that cycle's bit so no bit is lost between intervals
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			err_cnt_reg <= '0;
			bit_cnt_reg <= '0;
		end
		else if (clk_en)
		begin
			if (upd_state == BERTB_UPD_SNAP)
			begin
				err_cnt_reg <= {23'h000000, bit_err};
				bit_cnt_reg <= {31'h00000000, rx_bit_valid && !out_of_sync_in};
			end
			else
			begin
				if (bit_err && !(&err_cnt_reg))
					err_cnt_reg <= err_cnt_reg + `BERTB_ONE24;
				if (rx_bit_valid && !out_of_sync_in && !(&bit_cnt_reg))
					bit_cnt_reg <= bit_cnt_reg + `BERTB_ONE32;
			end
		end
	end

	// Update sequence: rise of request snapshots, then done until request falls
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			upd_state <= BERTB_UPD_IDLE;
			upd_prev_reg <= 1'b0;
			upd_done_reg <= 1'b0;
			err_snap_reg <= '0;
			bit_snap_reg <= '0;
		end
		else if (clk_en)
		begin
			upd_prev_reg <= upd_req;
			case (upd_state)
				BERTB_UPD_IDLE:
					if (upd_req && !upd_prev_reg)
						upd_state <= BERTB_UPD_SNAP;
				BERTB_UPD_SNAP:
				begin
					err_snap_reg <= err_cnt_reg;
					bit_snap_reg <= bit_cnt_reg;
					upd_state <= BERTB_UPD_DONE;
				end
				BERTB_UPD_DONE:
					upd_done_reg <= upd_req;
				default:
					upd_state <= BERTB_UPD_IDLE;
			endcase
			if (!upd_req && upd_state != BERTB_UPD_SNAP)
			begin
				upd_done_reg <= 1'b0;
				upd_state <= BERTB_UPD_IDLE;
			end
		end
	end

	// Count nonzero follows the live error tally; clears with the snapshot
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnz_reg <= 1'b0;
		else if (clk_en)
		begin
			if (upd_state == BERTB_UPD_SNAP)
				cnz_reg <= bit_err;
			else if (bit_err)
				cnz_reg <= 1'b1;
		end
	end

	assign status = {upd_done_reg, 1'b0, cnz_reg, out_of_sync_in};

	// ======================================================================
	// Latched flags: write one to clear; a new event wins over the clear
	logic [3:0] flag_set;
	logic [3:0] flag_clr;
	assign flag_set[`BERTB_ST_UPD] = upd_done_reg && !upd_done_prev_reg;
	assign flag_set[`BERTB_ST_BERR] = bit_err;
	assign flag_set[`BERTB_ST_CNZ] = cnz_reg && !cnz_prev_reg;
	assign flag_set[`BERTB_ST_OOS] = out_of_sync_in != oos_prev_reg;
	assign flag_clr = (wr && idx == `BERTB_IDX_LATCHED) ? req.writedata[3:0] : 4'h0;

	genvar gi;
	generate
		for (gi = 0; gi < `BERTB_FLAG_W; gi++)
		begin : g_flag
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
					latched_reg[gi] <= 1'b0;
				else if (clk_en)
					latched_reg[gi] <= flag_set[gi] || (latched_reg[gi] && !flag_clr[gi]);
			end
		end
	endgenerate

	// Edge history for the flag sources
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			oos_prev_reg <= 1'b0;
			cnz_prev_reg <= 1'b0;
			upd_done_prev_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			oos_prev_reg <= out_of_sync_in;
			cnz_prev_reg <= cnz_reg;
			upd_done_prev_reg <= upd_done_reg;
		end
	end

	// Interrupt request; port enable gates all but update done
	assign irq_request = (latched_reg[`BERTB_ST_UPD] && irqen_reg[`BERTB_ST_UPD])
		|| (port_irq_enable && |(latched_reg[2:0] & irqen_reg[2:0]));

	// ======================================================================
	// Checks
	a_err_saturate: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && (&err_cnt_reg) && upd_state != BERTB_UPD_SNAP |=> (&err_cnt_reg))
		else $error("error tally wrapped");
	a_bit_saturate: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && (&bit_cnt_reg) && upd_state != BERTB_UPD_SNAP |=> (&bit_cnt_reg))
		else $error("bit tally wrapped");
	a_err_oos_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && out_of_sync_in && upd_state != BERTB_UPD_SNAP
		|=> $stable(err_cnt_reg))
		else $error("error tally moved out of sync");
	a_bit_oos_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && out_of_sync_in && upd_state != BERTB_UPD_SNAP
		|=> $stable(bit_cnt_reg))
		else $error("bit tally moved out of sync");
	a_snap_only: assert property (@(posedge core_clk) disable iff (!rst_n)
		!$past(upd_state == BERTB_UPD_SNAP) |-> $stable(err_snap_reg)
		&& $stable(bit_snap_reg))
		else $error("snapshot changed without update");
	a_upd_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !upd_req |=> !upd_done_reg)
		else $error("update done stayed high");
	a_oos_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && (out_of_sync_in != oos_prev_reg) |=> latched_reg[`BERTB_ST_OOS])
		else $error("sync change not latched");
	a_berr_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && bit_err |=> latched_reg[`BERTB_ST_BERR] && cnz_reg)
		else $error("bit error not latched");
	a_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		!port_irq_enable && !(latched_reg[3] && irqen_reg[3]) |-> !irq_request)
		else $error("interrupt without enable");
	a_single_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ctrl_reg[`BERTB_CTL_SINGLE_EN] && rate_act_reg == 3'h0 && clk_en && tx_bit_valid
		|=> tx_data_out == $past(tx_data_in))
		else $error("error inserted while disabled");
endmodule
`default_nettype wire

// file: bertb_defs.svh
// Register offsets, field positions and reset values for the BERT error insert and tally block
`ifndef BERTB_DEFS_SVH
`define BERTB_DEFS_SVH
// Register byte offsets within one port: 0x60 plus twice the word address bits 4:0
`define BERTB_IDX_CTRL 8'h68
`define BERTB_IDX_STATUS 8'h6c
`define BERTB_IDX_LATCHED 8'h6e
`define BERTB_IDX_IRQEN 8'h70
`define BERTB_IDX_UPDCTL 8'h72
`define BERTB_IDX_ERR_LO 8'h74
`define BERTB_IDX_ERR_HI 8'h76
`define BERTB_IDX_BIT_LO 8'h78
`define BERTB_IDX_BIT_HI 8'h7a
// Insertion control field positions
`define BERTB_CTL_SRC 0
`define BERTB_CTL_TRIG 1
`define BERTB_CTL_SINGLE_EN 2
`define BERTB_CTL_RATE_LSB 3
`define BERTB_CTL_RATE_MSB 5
// Update control field positions
`define BERTB_UPD_LOCAL 0
`define BERTB_UPD_SRC 1
// Status and latched field positions
`define BERTB_ST_OOS 0
`define BERTB_ST_CNZ 1
`define BERTB_ST_BERR 2
`define BERTB_ST_UPD 3
`define BERTB_FLAG_W 4
`define BERTB_RST16 16'h0000
`define BERTB_RST4 4'h0
`define BERTB_ONE32 32'h00000001
`define BERTB_ONE24 24'h000001
`endif

// file: bertb_pkg.sv
// Types shared by the BERT error insert and tally block
`default_nettype none
package bertb_pkg;
	// Avalon-MM request as seen by the slave
	typedef struct packed {
		logic read;
		logic write;
		logic [9:0] address;
		logic [31:0] writedata;
	} bertb_req_s;
	// Update sequence states
	typedef enum logic [1:0] {
		BERTB_UPD_IDLE = 2'b00,
		BERTB_UPD_SNAP = 2'b01,
		BERTB_UPD_DONE = 2'b10
	} bertb_upd_e;
endpackage
`default_nettype wire

// file: bertb_stream_model.sv
// Serial test stream partner: feeds transmit bits, counts inverted ones, plays receive bits
`timescale 1ns/100ps
`default_nettype none
module bertb_stream_model
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic tx_go,
	input wire logic rx_go,
	input wire logic rx_flip,
	output logic tx_bit_valid,
	output logic tx_data_in,
	input wire logic tx_data_out,
	output logic rx_bit_valid,
	output logic rx_data,
	output logic rx_expected,
	output logic [15:0] tx_flips
);
	logic [3:0] pat_reg;
	logic sent_reg;
	logic valid_d_reg;
	// ==========================================
	// Stream drive
	// Pattern steps every cycle, so an idle line never repeats a stale bit
	assign tx_bit_valid = tx_go;
	assign tx_data_in = pat_reg[1];
	assign rx_bit_valid = rx_go;
	assign rx_expected = pat_reg[0];
	assign rx_data = pat_reg[0] ^ rx_flip;
	// Pattern generator
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			pat_reg <= 4'h1;
		else
			pat_reg <= {pat_reg[2:0], pat_reg[3] ^ pat_reg[2]};
	end
	// Output arrives one cycle after its valid bit; compare against what was sent
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			valid_d_reg <= 1'b0;
			sent_reg <= 1'b0;
			tx_flips <= 16'h0000;
		end
		else
		begin
			valid_d_reg <= tx_go;
			sent_reg <= pat_reg[1];
			if (valid_d_reg && (tx_data_out !== sent_reg))
				tx_flips <= tx_flips + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench: registers, single and rate errors, tallies, flags, interrupts
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [9:0] A_CTRL = 10'h024;
	localparam logic [9:0] A_ST = 10'h026;
	localparam logic [9:0] A_LAT = 10'h027;
	localparam logic [9:0] A_IE = 10'h028;
	localparam logic [9:0] A_UPD = 10'h029;
	logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, ext_in, out_of_sync, glob, port_en;
	logic clk_en;
	logic tx_go, rx_go, rx_flip, tx_bit_valid, tx_data_in, tx_data_out;
	logic rx_bit_valid, rx_data, rx_expected, irq_request;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [15:0] tx_flips, base, v;
	int mismatches, checked;
	bertb_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tx_bit_valid(tx_bit_valid),
		.tx_data_in(tx_data_in), .tx_data_out(tx_data_out),
		.external_error_insert_input(ext_in), .rx_bit_valid(rx_bit_valid),
		.rx_data(rx_data), .rx_expected(rx_expected), .out_of_sync_in(out_of_sync),
		.global_update_request(glob), .port_irq_enable(port_en), .irq_request(irq_request));
	bertb_stream_model i_far (.core_clk(core_clk), .rst_n(rst_n), .tx_go(tx_go),
		.rx_go(rx_go), .rx_flip(rx_flip), .tx_bit_valid(tx_bit_valid),
		.tx_data_in(tx_data_in), .tx_data_out(tx_data_out), .rx_bit_valid(rx_bit_valid),
		.rx_data(rx_data), .rx_expected(rx_expected), .tx_flips(tx_flips));
	// ==========================================
	// Clock, 4 ns period
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Verdict and end of run
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_rng(input string what, input int lo, input int hi, input logic [15:0] got);
		checked++;
		if ($isunknown(got) || got < lo || got > hi)
		begin
			mismatches++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	// ==========================================
	// Bus transfer: request held until waitrequest is sampled low; read data taken there
	task automatic bus(input logic rd_op, input logic [9:0] a, input logic [15:0] d);
		int n;
		@(posedge core_clk);
		avs_read <= rd_op;
		avs_write <= !rd_op;
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0)
		begin
			mismatches++;
			wrap_up();
		end
		else
		begin
			v = avs_readdata[15:0];
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		bus(1'b0, a, d);
	endtask
	task automatic rd(input logic [9:0] a, input logic [15:0] exp, input string what);
		bus(1'b1, a, 16'h0000);
		chk(what, exp, v);
	endtask
	task automatic irq_is(input logic e);
		@(posedge core_clk);
		chk("irq", {15'h0000, e}, {15'h0000, irq_request});
	endtask
	// Bounded poll of the status register until update done shows
	task automatic upd_wait();
		int n;
		n = 0;
		do
		begin
			bus(1'b1, A_ST, 16'h0000);
			n++;
		end
		while (v[3] !== 1'b1 && n < 20);
		if (v[3] !== 1'b1)
		begin
			mismatches++;
			wrap_up();
		end
	endtask
	// Stream bursts
	task automatic tx_run(input int n, input int lo, input int hi, input string what);
		base = tx_flips;
		@(posedge core_clk);
		tx_go <= 1'b1;
		repeat (n) @(posedge core_clk);
		tx_go <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk_rng(what, lo, hi, tx_flips - base);
	endtask
	task automatic rx_run(input int n, input int f);
		for (int i = 0; i < n; i++)
		begin
			@(posedge core_clk);
			rx_go <= 1'b1;
			rx_flip <= (i < f);
		end
		@(posedge core_clk);
		rx_go <= 1'b0;
		rx_flip <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask
	// Hang guard
	initial
	begin
		#200000;
		mismatches++;
		wrap_up();
	end
	// ==========================================
	// Main sequence
	initial
	begin
		{avs_read, avs_write, ext_in, out_of_sync, glob, port_en, tx_go, rx_go, rx_flip} = '0;
		clk_en = 1'b1;
		avs_address = 10'h000;
		avs_writedata = 32'h00000000;
		mismatches = 0;
		checked = 0;
		rst_n = 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(A_IE, 16'h0000, "irqen reset");
		rd(A_LAT, 16'h0000, "latched reset");
		wr(A_IE, 16'h000f);
		rd(A_IE, 16'h000f, "irqen rw");
		wr(10'h128, 16'h0000);
		rd(10'h128, 16'h0000, "other port");
		rd(A_IE, 16'h000f, "irqen kept");
		rd(10'h02f, 16'h0000, "unmapped");
		wr(A_IE, 16'h0000);
		// Receive errors in and out of sync
		rx_run(40, 3);
		rd(A_ST, 16'h0002, "status cnz");
		rd(A_LAT, 16'h0006, "latched err");
		out_of_sync <= 1'b1;
		rx_run(20, 5);
		rd(A_ST, 16'h0003, "status oos");
		rd(A_LAT, 16'h0007, "latched oos rise");
		wr(A_LAT, 16'h000f);
		out_of_sync <= 1'b0;
		rd(A_LAT, 16'h0001, "latched oos fall");
		wr(A_LAT, 16'h000f);
		rd(10'h02a, 16'h0000, "tally before update");
		// Local counter update
		wr(A_UPD, 16'h0001);
		upd_wait();
		rd(A_ST, 16'h0008, "status done");
		rd(10'h02a, 16'h0003, "err low");
		rd(10'h02b, 16'h0000, "err high");
		rd(10'h02c, 16'h0028, "bit low");
		rd(10'h02d, 16'h0000, "bit high");
		rd(A_LAT, 16'h0008, "latched done");
		irq_is(1'b0);
		wr(A_IE, 16'h0008);
		irq_is(1'b1);
		wr(A_UPD, 16'h0000);
		rd(A_ST, 16'h0000, "done falls");
		wr(A_LAT, 16'h000f);
		irq_is(1'b0);
		// Port enable gates the other flags
		rx_run(10, 1);
		wr(A_IE, 16'h0004);
		irq_is(1'b0);
		port_en <= 1'b1;
		irq_is(1'b1);
		wr(A_IE, 16'h0000);
		irq_is(1'b0);
		// Global update path; tallies restart per interval
		wr(A_UPD, 16'h0002);
		glob <= 1'b1;
		upd_wait();
		rd(A_ST, 16'h0008, "global done");
		rd(10'h02a, 16'h0001, "err low 2");
		rd(10'h02c, 16'h000a, "bit low 2");
		glob <= 1'b0;
		rd(A_ST, 16'h0000, "global falls");
		// Clock enable low freezes the registers, so the write is lost
		clk_en <= 1'b0;
		wr(A_IE, 16'h000f);
		clk_en <= 1'b1;
		rd(A_IE, 16'h0000, "frozen write");
		// Single errors; source toggled only with both triggers low
		wr(A_CTRL, 16'h0004);
		wr(A_CTRL, 16'h0006);
		tx_run(30, 1, 1, "single");
		wr(A_CTRL, 16'h0004);
		wr(A_CTRL, 16'h0006);
		wr(A_CTRL, 16'h0004);
		wr(A_CTRL, 16'h0006);
		wr(A_CTRL, 16'h0004);
		tx_run(30, 1, 1, "multi rise");
		wr(A_CTRL, 16'h0000);
		wr(A_CTRL, 16'h0002);
		wr(A_CTRL, 16'h0000);
		tx_run(30, 0, 0, "disabled");
		wr(A_CTRL, 16'h0005);
		@(posedge core_clk);
		ext_in <= 1'b1;
		@(posedge core_clk);
		ext_in <= 1'b0;
		tx_run(30, 1, 1, "external");
		wr(A_CTRL, 16'h0007);
		wr(A_CTRL, 16'h0005);
		tx_run(30, 0, 0, "reg ignored");
		wr(A_CTRL, 16'h0000);
		// Rate insertion, rates one to three
		for (int n = 1; n <= 3; n++)
		begin
			wr(A_CTRL, 16'(n << 3));
			tx_run(10 * (10 ** n), 9, 11, "rate");
		end
		wr(A_CTRL, 16'h0000);
		wrap_up();
	end
endmodule
`default_nettype wire
